// ==== pkg/rs_enc_pkg.sv ====
package rs_enc_pkg;

	// ----------------------------------------
	// Code dimensions
	// ----------------------------------------
	localparam int SYM_W = 8;
	localparam int N_CW = 255;
	localparam int E_HI = 16;
	localparam int E_LO = 8;
	localparam int PAR_MAX = 2 * E_HI;
	localparam int MAX_DEPTH = 8;
	localparam int CNT_W = 11;
	localparam int MARKER_SYMS = 4;
	localparam logic [5:0] NPAR_HI = 6'h20;
	localparam logic [5:0] NPAR_LO = 6'h10;
	localparam logic [7:0] K_HI = 8'hdf;
	localparam logic [7:0] K_LO = 8'hef;
	localparam logic [3:0] DEPTH_FALLBACK = 4'h1;

	// ----------------------------------------
	// Field and code constants
	// ----------------------------------------
	localparam logic [7:0] FIELD_POLY_LOW = 8'h87;
	localparam logic [7:0] ALPHA = 8'h02;
	localparam int ROOT_STEP = 11;
	localparam int ROOT_BASE = 128;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [SYM_W-1:0] sym_t;
	typedef logic [0:7][7:0] mat_t;
	typedef logic [0:PAR_MAX][7:0] coef_t;
	typedef enum logic [1:0] {S_IDLE, S_MARKER, S_INFO, S_PARITY} enc_state_t;
	typedef struct packed {
		sym_t data;
		logic sob;
		logic eob;
	} tx_sym_t;

	// Basis change rows, column 0 in the top bit
	localparam mat_t CONV_TO_DUAL = {8'h8d, 8'hef, 8'hec, 8'h86, 8'hfa, 8'h99, 8'haf, 8'h7b};
	localparam mat_t DUAL_TO_CONV = {8'hc5, 8'h42, 8'h2e, 8'hfd, 8'hf0, 8'h79, 8'hac, 8'hcc};

	// ----------------------------------------
	// Field arithmetic
	// ----------------------------------------
	function automatic sym_t gf_mul(input sym_t a, input sym_t b);
		sym_t p;
		sym_t x;
		p = '0;
		x = a;
		for (int i = 0; i < SYM_W; i++) begin
			if (b[i]) p = p ^ x;
			x = x[7] ? ({x[6:0], 1'b0} ^ FIELD_POLY_LOW) : {x[6:0], 1'b0};
		end
		return p;
	endfunction

	function automatic sym_t gf_alpha_pow(input int n);
		sym_t r;
		r = 8'h01;
		for (int i = 0; i < n; i++) r = gf_mul(r, ALPHA);
		return r;
	endfunction

	// Monic generator, roots alpha^(11j) for j = 128-e .. 127+e
	function automatic coef_t gen_poly(input int e);
		coef_t g;
		sym_t r;
		g = '0;
		g[0] = 8'h01;
		for (int j = ROOT_BASE - e; j <= ROOT_BASE - 1 + e; j++) begin
			r = gf_alpha_pow((ROOT_STEP * j) % N_CW);
			for (int i = PAR_MAX; i > 0; i--) g[i] = g[i-1] ^ gf_mul(g[i], r);
			g[0] = gf_mul(g[0], r);
		end
		return g;
	endfunction

	// Row vector [v7..v0] times matrix
	function automatic sym_t basis_map(input sym_t v, input mat_t m);
		sym_t o;
		o = '0;
		for (int i = 0; i < SYM_W; i++) begin
			if (v[7-i]) o = o ^ m[i];
		end
		return o;
	endfunction

	function automatic logic depth_ok(input logic [3:0] d);
		return (d >= 4'h1 && d <= 4'h5) || d == 4'h8;
	endfunction

	localparam coef_t GEN_E16 = gen_poly(E_HI);
	localparam coef_t GEN_E8 = gen_poly(E_LO);

endpackage

// ==== hw/interleaved_rs_block_encoder.sv ====
// Behaviour
// R01: Symbols are 8 bits; all field arithmetic works on 8-bit symbols.
// R02: Correction strength 16 or 8 selectable, choosing 32 or 16 parity symbols.
// R03: Codeword is 255 symbols, twice the strength of them parity.
// R04: Information symbols per codeword are 255 minus twice strength: 223 or 239.
// R05: Field multiply reduces by x^8+x^7+x^2+x+1.
// R06: Generator roots are alpha^(11j), j from 128-E to 127+E.
// R07: Systematic: information passes unchanged, parity appended after it.
// R08: Interleave depth is 1, 2, 3, 4, 5 or 8; one means none.
// R09: Configuring party keeps depth fixed on a channel for a mission phase.
// R10: Longest codeblock is 255 times depth symbols.
// R11: Parity cleared per block; computed over full length, fill taken as zero.
// R12: Fill count is a multiple of depth and below total information count.
// R13: Leading zero fill is never accepted as input nor emitted.
// R14: Depth times twice-strength parity symbols form the block tail.
// R15: A 32-bit sync marker goes out right before each codeblock.
// R16: Transmitted block is the frame, then the parity symbols.
// R17: Fill is zeros, untransmitted, fixed, same length at both ends.
// R18: Fill only at block start, after marker, whole multiples of depth symbols.
// R19: Output in dual basis, bit z0 first through z7 last.
// R20: Basis conversion uses the two fixed 8-by-8 matrices on u7..u0.
// R21: Receiver aligns blocks by locking to the sync marker.
// R22: Receiver decodes full logical block, reinserting the zero fill.
// R23: Receiver corrects up to 16 or 8 symbols per codeword.
// R24: Symbols go round-robin to lane encoders 1..depth, gathered in same order.
// R25: Source flags first symbol; parity follows with no further input.
`timescale 1ns/1ps
module interleaved_rs_block_encoder #(
	parameter logic [31:0] SYNC_MARKER = 32'h0000_0000,
	parameter int FIFO_DEPTH = 2
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Block configuration, sampled with the first symbol
	input wire logic cfg_e16,
	input wire logic [3:0] cfg_depth,
	input wire logic [10:0] cfg_fill,
	// Frame symbol input
	input wire logic in_valid,
	input wire logic in_sob,
	input wire logic [7:0] in_data,
	output logic in_ready,
	// Channel bit output
	output logic out_valid,
	input wire logic out_ready,
	output logic out_bit,
	output logic out_sob,
	output logic out_eob,
	// Status
	output logic busy
);
	localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int FCNT_W = $clog2(FIFO_DEPTH + 1);
	localparam logic [FCNT_W-1:0] FIFO_FULL = FCNT_W'(FIFO_DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);
	// ----------------------------------------
	// State
	// ----------------------------------------
	rs_enc_pkg::enc_state_t state_reg, state_next;
	logic e16_reg;
	logic [3:0] depth_reg;
	logic [10:0] info_total_reg;
	logic [10:0] info_left_reg;
	logic [2:0] lane_reg;
	logic [1:0] mk_idx_reg;
	logic [5:0] par_idx_reg;
	rs_enc_pkg::sym_t par_reg [rs_enc_pkg::MAX_DEPTH][rs_enc_pkg::PAR_MAX];
	logic in_ready_reg, busy_reg;
	// FIFO
	rs_enc_pkg::tx_sym_t fifo_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
	logic [FCNT_W-1:0] fifo_cnt_reg, fifo_cnt_next;
	// Serializer
	logic out_valid_reg, out_bit_reg, out_sob_reg, out_eob_reg, cur_eob_reg;
	logic [6:0] sh_reg;
	logic [2:0] rem_reg;
	logic start, accept, push, pop, fifo_space, last_lane, last_par, ser_load;
	logic [5:0] par_n;
	logic [7:0] k_sel;
	logic [10:0] k_total;
	rs_enc_pkg::sym_t lane_top, fb;
	rs_enc_pkg::tx_sym_t push_sym, head_sym;
	// ----------------------------------------
	// Control decode
	// ----------------------------------------
	// R25 start on flagged first symbol
	assign start = state_reg == rs_enc_pkg::S_IDLE && in_valid && in_sob;
	assign accept = in_valid && in_ready_reg;
	assign fifo_space = fifo_cnt_reg < FIFO_FULL;
	// R02 parity count follows strength
	assign par_n = e16_reg ? rs_enc_pkg::NPAR_HI : rs_enc_pkg::NPAR_LO;
	assign k_sel = cfg_e16 ? rs_enc_pkg::K_HI : rs_enc_pkg::K_LO;
	assign last_lane = {1'b0, lane_reg} == depth_reg - 4'h1;
	assign last_par = par_idx_reg == par_n - 6'h01;
	assign lane_top = e16_reg ? par_reg[lane_reg][rs_enc_pkg::PAR_MAX-1]
		: par_reg[lane_reg][2*rs_enc_pkg::E_LO-1];
	// R20 input to conventional basis before feedback
	assign fb = rs_enc_pkg::basis_map(in_data, rs_enc_pkg::DUAL_TO_CONV) ^ lane_top;
	assign head_sym = fifo_mem[rd_ptr_reg];

	// Symbols toward the buffer, and next state
	always_comb begin
		push = 1'b0;
		push_sym = '0;
		state_next = state_reg;
		unique case (state_reg)
			rs_enc_pkg::S_IDLE: begin
				if (start) state_next = rs_enc_pkg::S_MARKER;
			end
			// R15 marker first, high byte leading
			rs_enc_pkg::S_MARKER: begin
				if (fifo_space) begin
					push = 1'b1;
					push_sym.data = SYNC_MARKER[{~mk_idx_reg, 3'b000} +: 8];
					push_sym.sob = mk_idx_reg == 2'h0;
					if (mk_idx_reg == 2'h3) state_next = rs_enc_pkg::S_INFO;
				end
			end
			// R07 information passes unchanged
			rs_enc_pkg::S_INFO: begin
				if (accept) begin
					push = 1'b1;
					push_sym.data = in_data;
					if (info_left_reg == 11'h001) state_next = rs_enc_pkg::S_PARITY;
				end
			end
			// R16 parity after frame, converted to dual basis
			rs_enc_pkg::S_PARITY: begin
				if (fifo_space) begin
					push = 1'b1;
					push_sym.data = rs_enc_pkg::basis_map(lane_top, rs_enc_pkg::CONV_TO_DUAL);
					push_sym.eob = last_par && last_lane;
					if (push_sym.eob) state_next = rs_enc_pkg::S_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) state_reg <= rs_enc_pkg::S_IDLE;
		else state_reg <= state_next;
	end
	// ----------------------------------------
	// Block configuration
	// ----------------------------------------
	// R09 config taken once per block only; R08 unsupported depth falls back to one
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			e16_reg <= 1'b1;
			depth_reg <= rs_enc_pkg::DEPTH_FALLBACK;
		end else if (start) begin
			e16_reg <= cfg_e16;
			depth_reg <= rs_enc_pkg::depth_ok(cfg_depth) ? cfg_depth : rs_enc_pkg::DEPTH_FALLBACK;
		end
	end

	// R03 R04 R10 full information length is k times depth
	assign k_total = 11'(k_sel) * 11'(rs_enc_pkg::depth_ok(cfg_depth) ? cfg_depth
		: rs_enc_pkg::DEPTH_FALLBACK);
	// R13 R17 fill is never taken; only kI-Q symbols are counted in
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			info_total_reg <= '0;
			info_left_reg <= '0;
		end else if (start) begin
			info_total_reg <= k_total - cfg_fill;
			info_left_reg <= k_total - cfg_fill;
		end else if (accept) begin
			info_left_reg <= info_left_reg - 11'h001;
		end
	end
	// ----------------------------------------
	// Sequencing counters
	// ----------------------------------------
	// R24 round-robin lane, fill of whole depth multiples keeps lane 0 first (R18, R12)
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) lane_reg <= '0;
		else if (start) lane_reg <= '0;
		else if (accept || (state_reg == rs_enc_pkg::S_PARITY && push))
			lane_reg <= last_lane ? 3'h0 : lane_reg + 3'h1;
	end
	// Marker byte index, advances only when a byte is pushed
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) mk_idx_reg <= '0;
		else if (start) mk_idx_reg <= '0;
		else if (state_reg == rs_enc_pkg::S_MARKER && push) mk_idx_reg <= mk_idx_reg + 2'h1;
	end
	// R14 parity index walks once per full lane sweep
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) par_idx_reg <= '0;
		else if (start) par_idx_reg <= '0;
		else if (state_reg == rs_enc_pkg::S_PARITY && push && last_lane)
			par_idx_reg <= par_idx_reg + 6'h01;
	end

	// ----------------------------------------
	// Lane parity registers
	// ----------------------------------------
	// R11 cleared at block start; R01 R05 R06 byte-wide division by g(x)
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int l = 0; l < rs_enc_pkg::MAX_DEPTH; l++)
				for (int i = 0; i < rs_enc_pkg::PAR_MAX; i++) par_reg[l][i] <= '0;
		end else if (start) begin
			for (int l = 0; l < rs_enc_pkg::MAX_DEPTH; l++)
				for (int i = 0; i < rs_enc_pkg::PAR_MAX; i++) par_reg[l][i] <= '0;
		end else if (state_reg == rs_enc_pkg::S_INFO && accept) begin
			for (int i = 0; i < rs_enc_pkg::PAR_MAX; i++)
				par_reg[lane_reg][i] <= ((i == 0) ? 8'h00 : par_reg[lane_reg][(i == 0) ? 0 : i-1])
					^ rs_enc_pkg::gf_mul(fb, e16_reg ? rs_enc_pkg::GEN_E16[i] : rs_enc_pkg::GEN_E8[i]);
		end else if (state_reg == rs_enc_pkg::S_PARITY && push) begin
			for (int i = 0; i < rs_enc_pkg::PAR_MAX; i++)
				par_reg[lane_reg][i] <= (i == 0) ? 8'h00 : par_reg[lane_reg][(i == 0) ? 0 : i-1];
		end
	end

	// ----------------------------------------
	// Two-entry symbol buffer
	// ----------------------------------------
	// Ready is registered, so it looks one cycle ahead at the fill level
	assign fifo_cnt_next = fifo_cnt_reg + FCNT_W'(push) - FCNT_W'(pop);
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fifo_cnt_reg <= '0;
		end else begin
			if (push) wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PTR_W'(1);
			if (pop) rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PTR_W'(1);
			fifo_cnt_reg <= fifo_cnt_next;
		end
	end
	// Storage needs no reset, the count says which entries hold data
	always_ff @(posedge sys_clk) begin
		if (push) fifo_mem[wr_ptr_reg] <= push_sym;
	end
	// R13 input held off outside the information phase
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			in_ready_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			in_ready_reg <= state_next == rs_enc_pkg::S_INFO && fifo_cnt_next < FIFO_FULL
				&& !(state_reg == rs_enc_pkg::S_INFO && state_next != rs_enc_pkg::S_INFO);
			busy_reg <= state_next != rs_enc_pkg::S_IDLE;
		end
	end

	// ----------------------------------------
	// Bit serializer
	// ----------------------------------------
	assign ser_load = (!out_valid_reg || out_ready) && rem_reg == 3'h0 && fifo_cnt_reg != '0;
	assign pop = ser_load;
	// R19 z0 sits in the top bit and leaves first
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			out_valid_reg <= 1'b0;
			out_bit_reg <= 1'b0;
			out_sob_reg <= 1'b0;
			out_eob_reg <= 1'b0;
			cur_eob_reg <= 1'b0;
			sh_reg <= '0;
			rem_reg <= '0;
		end else if (!out_valid_reg || out_ready) begin
			if (rem_reg != 3'h0) begin
				out_valid_reg <= 1'b1;
				out_bit_reg <= sh_reg[6];
				sh_reg <= {sh_reg[5:0], 1'b0};
				rem_reg <= rem_reg - 3'h1;
				out_sob_reg <= 1'b0;
				out_eob_reg <= cur_eob_reg && rem_reg == 3'h1;
			end else if (ser_load) begin
				out_valid_reg <= 1'b1;
				out_bit_reg <= head_sym.data[7];
				sh_reg <= head_sym.data[6:0];
				rem_reg <= 3'h7;
				out_sob_reg <= head_sym.sob;
				out_eob_reg <= 1'b0;
				cur_eob_reg <= head_sym.eob;
			end else begin
				out_valid_reg <= 1'b0;
				out_sob_reg <= 1'b0;
				out_eob_reg <= 1'b0;
			end
		end
	end
	// Ports come straight from their flip-flops
	assign in_ready = in_ready_reg;
	assign out_valid = out_valid_reg;
	assign out_bit = out_bit_reg;
	assign out_sob = out_sob_reg;
	assign out_eob = out_eob_reg;
	assign busy = busy_reg;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [10:0] acc_cnt_reg;
	logic [8:0] par_cnt_reg;
	// Helper counts of taken symbols and emitted parity per block
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			acc_cnt_reg <= '0;
			par_cnt_reg <= '0;
		end else if (start) begin
			acc_cnt_reg <= '0;
			par_cnt_reg <= '0;
		end else begin
			if (accept) acc_cnt_reg <= acc_cnt_reg + 11'h001;
			if (state_reg == rs_enc_pkg::S_PARITY && push) par_cnt_reg <= par_cnt_reg + 9'h001;
		end
	end
	property p_marker_lead;
		@(posedge sys_clk) disable iff (reset)
		state_reg == rs_enc_pkg::S_MARKER && push && mk_idx_reg == 2'h3
			|=> state_reg == rs_enc_pkg::S_INFO ##0 (acc_cnt_reg == 11'h000);
	endproperty
	a_marker_lead: assert property (p_marker_lead) else $error("marker not right before frame"); // R15
	property p_no_fill_taken;
		@(posedge sys_clk) disable iff (reset)
		in_ready_reg |-> state_reg == rs_enc_pkg::S_INFO && info_left_reg != 11'h000;
	endproperty
	a_no_fill_taken: assert property (p_no_fill_taken) else $error("input taken outside frame"); // R13
	property p_info_len;
		@(posedge sys_clk) disable iff (reset)
		$rose(state_reg == rs_enc_pkg::S_PARITY) |-> acc_cnt_reg == info_total_reg;
	endproperty
	a_info_len: assert property (p_info_len) else $error("wrong information count"); // R04
	property p_parity_len;
		@(posedge sys_clk) disable iff (reset)
		push && push_sym.eob |-> par_cnt_reg + 9'h001 == 9'(par_n) * 9'(depth_reg);
	endproperty
	a_parity_len: assert property (p_parity_len) else $error("wrong parity count"); // R14
	property p_cleared;
		@(posedge sys_clk) disable iff (reset)
		start |=> par_reg[0][rs_enc_pkg::PAR_MAX-1] == 8'h00 && par_reg[0][0] == 8'h00;
	endproperty
	a_cleared: assert property (p_cleared) else $error("parity not cleared at start"); // R11
	property p_systematic;
		@(posedge sys_clk) disable iff (reset)
		accept |-> push && push_sym.data == in_data && !push_sym.eob;
	endproperty
	a_systematic: assert property (p_systematic) else $error("information altered"); // R07
	property p_round_robin;
		@(posedge sys_clk) disable iff (reset)
		(accept || (state_reg == rs_enc_pkg::S_PARITY && push)) && last_lane |=> lane_reg == 3'h0;
	endproperty
	a_round_robin: assert property (p_round_robin) else $error("lane order broken"); // R24
	property p_depth_legal;
		@(posedge sys_clk) disable iff (reset)
		state_reg != rs_enc_pkg::S_IDLE |-> rs_enc_pkg::depth_ok(depth_reg)
			&& 12'(info_total_reg) + 12'(par_n) * 12'(depth_reg) <= 12'(rs_enc_pkg::N_CW) * 12'(depth_reg);
	endproperty
	a_depth_legal: assert property (p_depth_legal) else $error("depth or length out of range"); // R10
	property p_bit_order;
		@(posedge sys_clk) disable iff (reset)
		ser_load |=> out_valid_reg && out_bit_reg == $past(head_sym.data[7]) && rem_reg == 3'h7;
	endproperty
	a_bit_order: assert property (p_bit_order) else $error("z0 not sent first"); // R19

	c_e8_block: cover property (@(posedge sys_clk) disable iff (reset) push && push_sym.eob && !e16_reg);
	c_e16_deep: cover property (@(posedge sys_clk) disable iff (reset)
		push && push_sym.eob && e16_reg && depth_reg == 4'h8);
	c_buf_full: cover property (@(posedge sys_clk) disable iff (reset)
		fifo_cnt_reg == FIFO_FULL && out_valid_reg && !out_ready);
	c_shortened: cover property (@(posedge sys_clk) disable iff (reset)
		$rose(state_reg == rs_enc_pkg::S_PARITY) && info_total_reg < 11'(rs_enc_pkg::K_HI));

endmodule

// ==== dv/channel_sink.sv ====
`timescale 1ns/1ps
module channel_sink (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Serial channel bits from the encoder
	input wire logic out_valid,
	input wire logic out_bit,
	input wire logic out_sob,
	input wire logic out_eob,
	output logic out_ready,
	// Pacing from the bench, high to stall this cycle
	input wire logic hold_off
);
	logic [2:0] seen_q[$];

	// Ready moves only on the falling edge, away from the sampling edge
	initial out_ready = 1'b0;
	always @(negedge sys_clk) begin
		out_ready = !reset && !hold_off;
	end

	// Every accepted bit is kept with its block flags, start flag marks the first marker bit
	always @(posedge sys_clk) begin
		if (!reset && out_valid && out_ready) begin
			seen_q.push_back({out_sob, out_eob, out_bit});
		end
	end
endmodule

// ==== dv/interleaved_rs_block_encoder_test.sv ====
`timescale 1ns/1ps
module interleaved_rs_block_encoder_test;
	// Marker pattern is arbitrary, only its bit order matters here
	localparam logic [31:0] MARKER = 32'h5a3c_96e1;
	logic sys_clk, reset, cfg_e16, in_valid, in_sob, in_ready;
	logic out_valid, out_ready, out_bit, out_sob, out_eob, busy;
	logic slow, hold_off;
	logic [3:0] cfg_depth;
	logic [10:0] cfg_fill;
	logic [7:0] in_data;
	logic [15:0] lfsr_reg, pace_reg;
	int num_errors, n_tests;
	rs_enc_pkg::sym_t gen[0:32];
	rs_enc_pkg::sym_t par[0:7][0:31];
	rs_enc_pkg::sym_t exp_q[$];

	interleaved_rs_block_encoder #(.SYNC_MARKER(MARKER)) u_interleaved_rs_block_encoder (
		.sys_clk(sys_clk), .reset(reset), .cfg_e16(cfg_e16), .cfg_depth(cfg_depth),
		.cfg_fill(cfg_fill), .in_valid(in_valid), .in_sob(in_sob), .in_data(in_data),
		.in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready), .out_bit(out_bit),
		.out_sob(out_sob), .out_eob(out_eob), .busy(busy));

	channel_sink u_channel_sink (.sys_clk(sys_clk), .reset(reset), .out_valid(out_valid),
		.out_bit(out_bit), .out_sob(out_sob), .out_eob(out_eob), .out_ready(out_ready),
		.hold_off(hold_off));

	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	function automatic logic [15:0] lfsr_step(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic rs_enc_pkg::sym_t mul(input rs_enc_pkg::sym_t a, input rs_enc_pkg::sym_t b);
		int p;
		int x;
		p = 0;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) p = p ^ x;
			x = x << 1;
			if (x > 255) x = x ^ 'h187;
		end
		return rs_enc_pkg::sym_t'(p);
	endfunction

	function automatic rs_enc_pkg::sym_t remap(input rs_enc_pkg::sym_t v, input rs_enc_pkg::mat_t m);
		rs_enc_pkg::sym_t o;
		o = '0;
		for (int i = 0; i < 8; i++) begin
			if (v[7-i]) o = o ^ m[i];
		end
		return o;
	endfunction

	task automatic build_gen(input int e);
		rs_enc_pkg::sym_t r;
		for (int i = 0; i <= 32; i++) gen[i] = '0;
		gen[0] = 8'h01;
		for (int j = 128 - e; j <= 127 + e; j++) begin
			r = 8'h01;
			for (int m = 0; m < (11 * j) % 255; m++) r = mul(r, 8'h02);
			for (int i = 2 * e; i > 0; i--) gen[i] = gen[i-1] ^ mul(gen[i], r);
			gen[0] = mul(gen[0], r);
		end
	endtask

	// Systematic division of one lane by the generator
	task automatic lane_feed(input int ln, input int np, input rs_enc_pkg::sym_t u);
		rs_enc_pkg::sym_t fb;
		fb = u ^ par[ln][np-1];
		for (int i = np - 1; i > 0; i--) par[ln][i] = par[ln][i-1] ^ mul(fb, gen[i]);
		par[ln][0] = mul(fb, gen[0]);
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results;
		$display("Checks made %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----------------------------------------
	// One block: drive, model, compare
	// ----------------------------------------
	task automatic run_block(input logic e16, input logic [3:0] d, input int q, input logic sl);
		int de, np, ns, nb, t;
		rs_enc_pkg::sym_t u;
		logic [7:0] sb, fs, fe;
		logic [2:0] b;
		rs_enc_pkg::sym_t acc, r;
		rs_enc_pkg::sym_t rx_q[$];
		de = (d inside {1, 2, 3, 4, 5, 8}) ? int'(d) : 1;
		np = e16 ? 32 : 16;
		ns = (255 - np) * de - q;
		build_gen(np / 2);
		for (int a = 0; a < 8; a++)
			for (int c = 0; c < 32; c++) par[a][c] = '0;
		exp_q = {MARKER[31:24], MARKER[23:16], MARKER[15:8], MARKER[7:0]};
		for (int f = 0; f < q; f++) lane_feed(f % de, np, 8'h00);
		slow = sl;
		@(negedge sys_clk);
		cfg_e16 = e16;
		cfg_depth = d;
		cfg_fill = 11'(q);
		in_valid = 1'b1;
		in_sob = 1'b0;
		repeat (3) @(negedge sys_clk);
		check("ready_idle", in_ready, 0);
		check("sink_idle", u_channel_sink.seen_q.size(), 0);
		for (int n = 0; n < ns; n++) begin
			if (sl && lfsr_reg[9]) begin
				in_valid = 1'b0;
				@(negedge sys_clk);
			end
			lfsr_reg = lfsr_step(lfsr_reg);
			u = lfsr_reg[7:0];
			in_valid = 1'b1;
			in_sob = (n == 0);
			in_data = u;
			exp_q.push_back(u);
			lane_feed(n % de, np, remap(u, rs_enc_pkg::DUAL_TO_CONV));
			t = 0;
			while (in_ready !== 1'b1 && t < 4000) begin
				@(negedge sys_clk);
				t++;
			end
			if (t == 4000) check("ready_wait", 0, 1);
			@(negedge sys_clk);
			if (n == 0) check("busy_run", busy, 1);
		end
		in_valid = 1'b0;
		in_sob = 1'b0;
		for (int p = 0; p < np; p++) begin
			for (int ln = 0; ln < de; ln++) exp_q.push_back(remap(par[ln][np-1-p], rs_enc_pkg::CONV_TO_DUAL));
		end
		nb = exp_q.size() * 8;
		t = 0;
		while ((u_channel_sink.seen_q.size() < nb || busy !== 1'b0) && t < 40000) begin
			@(negedge sys_clk);
			t++;
		end
		repeat (4) @(negedge sys_clk);
		check("bit_count", u_channel_sink.seen_q.size(), nb);
		check("valid_end", out_valid, 0);
		for (int i = 0; i < exp_q.size(); i++) begin
			for (int j = 0; j < 8; j++) begin
				b = u_channel_sink.seen_q[8 * i + j];
				{fs[7-j], fe[7-j], sb[7-j]} = b;
			end
			check("sym", sb, exp_q[i]);
			rx_q.push_back(sb);
			check("sob", fs, (i == 0) ? 8'h80 : 8'h00);
			check("eob", fe, (i == exp_q.size() - 1) ? 8'h01 : 8'h00);
		end
		// Each received lane word must vanish at all 2E roots, or the far decoder cannot correct
		for (int ln = 0; ln < de; ln++) begin
			for (int j = 128 - np / 2; j <= 127 + np / 2; j++) begin
				r = 8'h01;
				for (int m = 0; m < (11 * j) % 255; m++) r = mul(r, 8'h02);
				acc = 8'h00;
				for (int s = 4 + ln; s < rx_q.size(); s += de)
					acc = mul(acc, r) ^ remap(rx_q[s], rs_enc_pkg::DUAL_TO_CONV);
				check("root", acc, 8'h00);
			end
		end
		u_channel_sink.seen_q.delete();
	endtask

	// ----------------------------------------
	// Clock, pacing, sequence, watchdog
	// ----------------------------------------
	initial sys_clk = 1'b0;
	always #20 sys_clk = ~sys_clk;

	// Stall pattern is set on the rising edge so the sink reads it settled
	initial pace_reg = 16'h62e4;
	always @(posedge sys_clk) begin
		pace_reg <= lfsr_step(pace_reg);
		hold_off <= slow && pace_reg[4];
	end

	initial begin
		reset = 1'b1;
		cfg_e16 = 1'b0;
		cfg_depth = 4'h1;
		cfg_fill = 11'h000;
		in_valid = 1'b0;
		in_sob = 1'b0;
		in_data = 8'h00;
		slow = 1'b0;
		hold_off = 1'b0;
		lfsr_reg = 16'h62e4;
		num_errors = 0;
		n_tests = 0;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		check("reset_out", {in_ready, out_valid, out_bit, out_sob, out_eob, busy}, 0);
		reset = 1'b0;
		// strengths and depths, boundary fill, illegal depth
		run_block(1'b1, 4'h1, 0, 1'b0);
		run_block(1'b0, 4'h5, 1000, 1'b1);
		run_block(1'b1, 4'h8, 1600, 1'b0);
		run_block(1'b0, 4'h2, 400, 1'b1);
		run_block(1'b1, 4'h3, 600, 1'b0);
		run_block(1'b0, 4'h4, 952, 1'b1);
		run_block(1'b1, 4'h6, 200, 1'b0);
		results();
	end

	// Blocks above need about 15000 cycles, so this only trips on a hang
	initial begin
		#(64'd40 * 60000);
		check("watchdog", 0, 1);
		results();
	end
endmodule
